// ---- scbr_defines.svh ----
`ifndef SCBR_DEFINES_SVH
`define SCBR_DEFINES_SVH
// Register addresses on the plain port (chosen map)
`define SCBR_ADDR_CTRL2 4'h0
`define SCBR_ADDR_BAUD 4'h1
`define SCBR_ADDR_STAT 4'h2
`define SCBR_ADDR_DATA 4'h3
`define SCBR_ADDR_CTRL1 4'h4
`define SCBR_ADDR_IRQ_STAT 4'h5
`define SCBR_ADDR_IRQ_MASK 4'h6
// Control register two bit positions
`define SCBR_C2_MODE_FAULT_ENABLE 4
`define SCBR_C2_OE 3
`define SCBR_C2_SWAI 1
`define SCBR_C2_SPC 0
`define SCBR_C2_MASK 8'h1B
// Baud register fields
`define SCBR_BR_PRE_HI 6
`define SCBR_BR_PRE_LO 4
`define SCBR_BR_DIV_HI 2
`define SCBR_BR_DIV_LO 0
`define SCBR_BR_MASK 8'h77
// Status bit positions
`define SCBR_ST_RXF 7
`define SCBR_ST_TXE 5
`define SCBR_ST_MODE_FAULT_FLAG 4
// Interrupt event bit positions
`define SCBR_EV_RXF 0
`define SCBR_EV_TXE 1
`define SCBR_EV_MODE_FAULT_FLAG 2
`define SCBR_EV_W 3
// Reset values
`define SCBR_RST_C2 8'h00
`define SCBR_RST_BR 8'h00
`endif

// ---- scbr_pkg.sv ----
package scbr_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scbr_bus_t;
  typedef struct packed {
    logic out;
    logic oe_n;
  } scbr_pin_t;
  typedef enum logic [1:0] {
    SCBR_SS_GPIO,
    SCBR_SS_FAULT_IN,
    SCBR_SS_AUTO_OUT,
    SCBR_SS_SLAVE_IN
  } scbr_ss_mode_t;
endpackage : scbr_pkg

// ---- scbr_sync.sv ----
`timescale 1ns/100ps
// Three-stage synchroniser; a change is accepted when stages two and three agree
module scbr_sync (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic d_i,
  output logic q_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;
  // Shift chain, first stage feeds only the second
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      q_r <= 1'b1;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_r <= s3_r;
      end
    end
  end
  assign q_o = q_r;
endmodule : scbr_sync

// ---- scbr_ctrl.sv ----
`timescale 1ns/100ps
`include "scbr_defines.svh"
// What this block does
// - Control two keeps bits 4,3,1,0 only
// - Slave mode: select pin is slave input
// - Master: fault enable picks pin role
// - Single-wire: output enable drives shared pin
// - Output enable ignored outside single-wire
// - Stop bit halts clocks in wait
// - Single-wire uses slave-out or master-out pin
// - Normal mode uses separate in/out pins
// - Baud register accessible at any time
// - Prescaler divides by field plus one
// - Divider divides by two power field+1
// - Status has three flags, writes ignored
// - Receive flag: set done, read-read clears
// - Transmit empty: read then data write
// - Mode fault set, cleared by read-ctrl1-write
module scbr_ctrl (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire scbr_pkg::scbr_bus_t BUS_I,
  output logic [7:0] RDATA_O,
  input wire logic MASTER_SELECT_I,
  input wire logic SPI_ENABLE_I,
  input wire logic SELECT_OUTPUT_ENABLE_I,
  input wire logic XFER_DONE_I,
  input wire logic TX_LOADED_I,
  input wire logic WAIT_MODE_I,
  input wire logic SELECT_PIN_I,
  input wire logic AUTO_SELECT_I,
  input wire logic SHIFT_OUT_I,
  input wire logic MOSI_IN_I,
  input wire logic MISO_IN_I,
  output scbr_pkg::scbr_pin_t MOSI_PIN_O,
  output scbr_pkg::scbr_pin_t MISO_PIN_O,
  output scbr_pkg::scbr_pin_t SELECT_PIN_O,
  output logic SHIFT_IN_O,
  output scbr_pkg::scbr_ss_mode_t SS_MODE_O,
  output logic SPI_CLK_RUN_O,
  output logic BIT_TICK_O,
  output logic TX_WRITE_O,
  output logic RX_READ_O,
  output logic IRQ_O
);
  import scbr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ctrl2_r;
  logic [7:0] baud_r;
  logic rxf_r;
  logic txe_r;
  logic mode_fault_flag_r;
  logic rxf_armed_r;
  logic txe_armed_r;
  logic mode_fault_flag_armed_r;
  logic [`SCBR_EV_W-1:0] irq_stat_r;
  logic [`SCBR_EV_W-1:0] irq_mask_r;
  logic [7:0] rdata_r;
  logic [2:0] pre_cnt_r;
  logic [7:0] div_cnt_r;
  logic tick_r;
  logic ss_sync;
  logic ss_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire wr_c2 = BUS_I.wr && (BUS_I.addr == `SCBR_ADDR_CTRL2);
  wire wr_br = BUS_I.wr && (BUS_I.addr == `SCBR_ADDR_BAUD);
  wire wr_data = BUS_I.wr && (BUS_I.addr == `SCBR_ADDR_DATA);
  wire wr_c1 = BUS_I.wr && (BUS_I.addr == `SCBR_ADDR_CTRL1);
  wire wr_imask = BUS_I.wr && (BUS_I.addr == `SCBR_ADDR_IRQ_MASK);
  wire rd_stat = BUS_I.rd && (BUS_I.addr == `SCBR_ADDR_STAT);
  wire rd_data = BUS_I.rd && (BUS_I.addr == `SCBR_ADDR_DATA);
  wire rd_istat = BUS_I.rd && (BUS_I.addr == `SCBR_ADDR_IRQ_STAT);

  // Field views of control two and the baud register
  wire mode_fault_enable = ctrl2_r[`SCBR_C2_MODE_FAULT_ENABLE];
  wire bidir_oe = ctrl2_r[`SCBR_C2_OE];
  wire stop_in_wait = ctrl2_r[`SCBR_C2_SWAI];
  wire single_wire_select = ctrl2_r[`SCBR_C2_SPC];
  wire [2:0] baud_prescale_field = baud_r[`SCBR_BR_PRE_HI:`SCBR_BR_PRE_LO];
  wire [2:0] baud_divider_field = baud_r[`SCBR_BR_DIV_HI:`SCBR_BR_DIV_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Wait gating: clocks stop only when the stop bit is set
  wire clk_run = !(WAIT_MODE_I && stop_in_wait);
  assign SPI_CLK_RUN_O = clk_run;

  ////////////////////////////////////////////////////////////////////////////
  // Select pin role
  scbr_ss_mode_t ss_mode;
  assign ss_mode = !MASTER_SELECT_I ? SCBR_SS_SLAVE_IN :
                   !mode_fault_enable ? SCBR_SS_GPIO :
                   SELECT_OUTPUT_ENABLE_I ? SCBR_SS_AUTO_OUT : SCBR_SS_FAULT_IN;
  assign SS_MODE_O = ss_mode;
  // Enable is low while driving; drive only as automatic select output
  assign SELECT_PIN_O.out = AUTO_SELECT_I;
  assign SELECT_PIN_O.oe_n = !(SPI_ENABLE_I && ss_mode == SCBR_SS_AUTO_OUT);

  ////////////////////////////////////////////////////////////////////////////
  // Data pin steering
  wire sw_drive = single_wire_select && bidir_oe;
  wire master_out = SPI_ENABLE_I && MASTER_SELECT_I &&
                    (single_wire_select ? sw_drive : 1'b1);
  wire slave_out = SPI_ENABLE_I && !MASTER_SELECT_I &&
                   (single_wire_select ? sw_drive : 1'b1);
  assign MOSI_PIN_O.out = SHIFT_OUT_I;
  assign MOSI_PIN_O.oe_n = !master_out;
  assign MISO_PIN_O.out = SHIFT_OUT_I;
  assign MISO_PIN_O.oe_n = !slave_out;
  // Shared pin carries input in single-wire; otherwise the opposite pin
  assign SHIFT_IN_O = single_wire_select ? (MASTER_SELECT_I ? MOSI_IN_I : MISO_IN_I) :
                      (MASTER_SELECT_I ? MISO_IN_I : MOSI_IN_I);

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator: prescaler count wraps at field, divider at 2^(f+1)-1
  wire pre_wrap = (pre_cnt_r == baud_prescale_field);
  wire [7:0] div_last = 8'((9'h002 << baud_divider_field) - 9'h001);
  wire div_wrap = pre_wrap && (div_cnt_r >= div_last);
  wire baud_run = clk_run && SPI_ENABLE_I && MASTER_SELECT_I;

  // Counters restart when the rate is rewritten so a new rate starts clean
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pre_cnt_r <= 3'h0;
      div_cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else if (!baud_run || wr_br) begin
      pre_cnt_r <= 3'h0;
      div_cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      pre_cnt_r <= pre_wrap ? 3'h0 : pre_cnt_r + 3'h1;
      if (pre_wrap) begin
        div_cnt_r <= div_wrap ? 8'h00 : div_cnt_r + 8'h01;
      end
      tick_r <= div_wrap;
    end
  end
  assign BIT_TICK_O = tick_r;

  ////////////////////////////////////////////////////////////////////////////
  // Mode fault detection on the synchronised select pin
  scbr_sync u_ss_sync (
    .MCLK_I(MCLK_I),
    .RESETN_I(RESETN_I),
    .d_i(SELECT_PIN_I),
    .q_o(ss_sync)
  );
  wire mode_fault_flag_event = (ss_mode == SCBR_SS_FAULT_IN) && SPI_ENABLE_I &&
                    ss_prev_r && !ss_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Flag clear sequences: status read with flag set arms the clear
  wire rxf_clr = rd_data && rxf_armed_r;
  wire txe_clr = wr_data && txe_armed_r;
  wire mode_fault_flag_clr = wr_c1 && mode_fault_flag_armed_r;
  assign TX_WRITE_O = txe_clr; // Unarmed data writes are dropped
  assign RX_READ_O = rd_data;

  // Status flags; a set in the same cycle as a clear wins
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rxf_r <= 1'b0;
      txe_r <= 1'b1;
      mode_fault_flag_r <= 1'b0;
      ss_prev_r <= 1'b1;
    end else begin
      ss_prev_r <= ss_sync;
      rxf_r <= SPI_ENABLE_I && ((XFER_DONE_I) || (rxf_r && !rxf_clr));
      txe_r <= !SPI_ENABLE_I || TX_LOADED_I || (txe_r && !txe_clr);
      mode_fault_flag_r <= mode_fault_flag_event || (mode_fault_flag_r && !mode_fault_flag_clr);
    end
  end

  // Arming: a status read while the flag is set, consumed by the clear access
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rxf_armed_r <= 1'b0;
      txe_armed_r <= 1'b0;
      mode_fault_flag_armed_r <= 1'b0;
    end else begin
      rxf_armed_r <= (rd_stat && rxf_r) || (rxf_armed_r && rxf_r && !rxf_clr);
      txe_armed_r <= (rd_stat && txe_r) || (txe_armed_r && txe_r && !txe_clr);
      mode_fault_flag_armed_r <= (rd_stat && mode_fault_flag_r) || (mode_fault_flag_armed_r && mode_fault_flag_r && !mode_fault_flag_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers; only implemented bits are stored
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctrl2_r <= `SCBR_RST_C2;
      baud_r <= `SCBR_RST_BR;
      irq_mask_r <= '0;
    end else begin
      if (wr_c2) begin
        ctrl2_r <= BUS_I.wdata & `SCBR_C2_MASK;
      end
      if (wr_br) begin
        baud_r <= BUS_I.wdata & `SCBR_BR_MASK; // No transfer interlock
      end
      if (wr_imask) begin
        irq_mask_r <= BUS_I.wdata[`SCBR_EV_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events: the flag set conditions while enabled, each cycle they hold, sticky until read
  wire [`SCBR_EV_W-1:0] ev_set;
  assign ev_set[`SCBR_EV_RXF] = XFER_DONE_I && SPI_ENABLE_I;
  assign ev_set[`SCBR_EV_TXE] = TX_LOADED_I && SPI_ENABLE_I;
  assign ev_set[`SCBR_EV_MODE_FAULT_FLAG] = mode_fault_flag_event;

  // Read clears, but a same-cycle event survives
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= ev_set | (rd_istat ? '0 : irq_stat_r);
    end
  end
  assign IRQ_O = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; status writes fall through with no effect
  logic [7:0] stat_val;
  always_comb begin
    stat_val = 8'h00;
    stat_val[`SCBR_ST_RXF] = rxf_r;
    stat_val[`SCBR_ST_TXE] = txe_r;
    stat_val[`SCBR_ST_MODE_FAULT_FLAG] = mode_fault_flag_r;
  end
  wire [7:0] rd_mux = (BUS_I.addr == `SCBR_ADDR_CTRL2) ? ctrl2_r :
                      (BUS_I.addr == `SCBR_ADDR_BAUD) ? baud_r :
                      (BUS_I.addr == `SCBR_ADDR_STAT) ? stat_val :
                      (BUS_I.addr == `SCBR_ADDR_IRQ_STAT) ? {5'h00, irq_stat_r} :
                      (BUS_I.addr == `SCBR_ADDR_IRQ_MASK) ? {5'h00, irq_mask_r} : 8'h00;

  // Read data stands one cycle after the strobe only
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= BUS_I.rd ? rd_mux : 8'h00;
    end
  end
  assign RDATA_O = rdata_r;
endmodule : scbr_ctrl

// ---- scbr_ctrl_sva.sv ----
`timescale 1ns/100ps
module scbr_ctrl_sva (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire scbr_pkg::scbr_bus_t BUS_I,
  input wire logic [7:0] RDATA_O,
  input wire logic MASTER_SELECT_I,
  input wire logic SPI_ENABLE_I,
  input wire logic WAIT_MODE_I,
  input wire logic SHIFT_OUT_I,
  input wire logic MISO_IN_I,
  input wire scbr_pkg::scbr_pin_t MOSI_PIN_O,
  input wire scbr_pkg::scbr_pin_t MISO_PIN_O,
  input wire logic RX_READ_O,
  input wire logic SHIFT_IN_O,
  input wire scbr_pkg::scbr_ss_mode_t SS_MODE_O,
  input wire logic SPI_CLK_RUN_O,
  input wire logic BIT_TICK_O,
  input wire logic TX_WRITE_O,
  input wire logic IRQ_O
);
  import scbr_pkg::*;
  logic [7:0] c2_r;
  wire ms = SPI_ENABLE_I && MASTER_SELECT_I;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  // Shadow of control two, so pin checks know the mode bits
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) c2_r <= 8'h00;
    else if (BUS_I.wr && BUS_I.addr == 4'h0) c2_r <= BUS_I.wdata;
  end
  ////////////////////////////////////////////////////////////
  property p_c2; $past(BUS_I.rd && BUS_I.addr == 4'h0) |-> (RDATA_O & 8'hE4) == 8'h00; endproperty
  a_c2: assert property (p_c2) else $error("ctrl2 unused bit read high");
  property p_br; $past(BUS_I.rd && BUS_I.addr == 4'h1) |-> (RDATA_O & 8'h88) == 8'h00; endproperty
  a_br: assert property (p_br) else $error("baud unused bit read high");
  property p_st; $past(BUS_I.rd && BUS_I.addr == 4'h2) |-> (RDATA_O & 8'h4F) == 8'h00; endproperty
  a_st: assert property (p_st) else $error("status unused bit read high");
  property p_slv; SPI_ENABLE_I && !MASTER_SELECT_I |-> SS_MODE_O == SCBR_SS_SLAVE_IN; endproperty
  a_slv: assert property (p_slv) else $error("slave select role wrong");
  property p_gpio; ms && !c2_r[4] |-> SS_MODE_O == SCBR_SS_GPIO; endproperty
  a_gpio: assert property (p_gpio) else $error("select pin not released");
  // Output enable bit must not matter here, so it is left out of the cause
  property p_sep; ms && !c2_r[0] |-> !MOSI_PIN_O.oe_n && MOSI_PIN_O.out == SHIFT_OUT_I && SHIFT_IN_O == MISO_IN_I;
  endproperty
  a_sep: assert property (p_sep) else $error("two-pin data path wrong");
  property p_bid; ms && c2_r[0] |-> MOSI_PIN_O.oe_n == !c2_r[3]; endproperty
  a_bid: assert property (p_bid) else $error("shared pin driver wrong");
  property p_run; 1'b1 |-> SPI_CLK_RUN_O == !(WAIT_MODE_I && c2_r[1]); endproperty
  a_run: assert property (p_run) else $error("clock run wrong in wait");
  property p_tick; BIT_TICK_O |=> !BIT_TICK_O; endproperty
  a_tick: assert property (p_tick) else $error("bit tick faster than two");
  property p_txw; TX_WRITE_O |-> BUS_I.wr && BUS_I.addr == 4'h3; endproperty
  a_txw: assert property (p_txw) else $error("tx write without data write");
  // Slave side: the slave-out pin is the data output or the shared pin
  property p_ssep; SPI_ENABLE_I && !MASTER_SELECT_I && !c2_r[0] |-> !MISO_PIN_O.oe_n; endproperty
  a_ssep: assert property (p_ssep) else $error("slave two-pin output wrong");
  property p_sbid; SPI_ENABLE_I && !MASTER_SELECT_I && c2_r[0] |-> MISO_PIN_O.oe_n == !c2_r[3]; endproperty
  a_sbid: assert property (p_sbid) else $error("slave shared pin driver wrong");
  property p_rxr; RX_READ_O == (BUS_I.rd && BUS_I.addr == 4'h3); endproperty
  a_rxr: assert property (p_rxr) else $error("data read pulse wrong");
  c_tick: cover property (BIT_TICK_O);
  c_txw: cover property (TX_WRITE_O);
  c_irq: cover property (IRQ_O);
endmodule : scbr_ctrl_sva
bind scbr_ctrl scbr_ctrl_sva u_sva (.MCLK_I, .RESETN_I, .BUS_I, .RDATA_O, .MASTER_SELECT_I, .SPI_ENABLE_I,
  .WAIT_MODE_I, .SHIFT_OUT_I, .MISO_IN_I, .MOSI_PIN_O, .MISO_PIN_O, .RX_READ_O, .SHIFT_IN_O, .SS_MODE_O, .SPI_CLK_RUN_O,
  .BIT_TICK_O, .TX_WRITE_O, .IRQ_O);

// ---- scbr_peer.sv ----
`timescale 1ns/100ps
module scbr_peer (
  input wire logic mclk_i,
  input wire logic fault_i,
  input wire scbr_pkg::scbr_pin_t mosi_pin_i,
  input wire scbr_pkg::scbr_pin_t miso_pin_i,
  input wire scbr_pkg::scbr_pin_t sel_pin_i,
  output logic mosi_o,
  output logic miso_o,
  output logic sel_o
);
  import scbr_pkg::*;
  logic pat_r = 1'b0;
  // Peer data toggles every cycle, so a stale level never passes as driven data
  always_ff @(posedge mclk_i) pat_r <= ~pat_r;
  // Wire levels resolved from the device enables
  assign mosi_o = mosi_pin_i.oe_n ? pat_r : mosi_pin_i.out;
  assign miso_o = miso_pin_i.oe_n ? ~pat_r : miso_pin_i.out;
  // Select line has a pull-up; a second master pulls it low
  assign sel_o = !sel_pin_i.oe_n ? sel_pin_i.out : !fault_i;
endmodule : scbr_peer

// ---- spi_ctrl2_baud_status_test.sv ----
`timescale 1ns/100ps
module spi_ctrl2_baud_status_test;
  import scbr_pkg::*;
  logic mclk, rst_n, master, en, select_output_enable, done, loaded, waitm, auto, shout, fault;
  logic mosi_in, miso_in, sel_in, shin, run, tick, txw, rxr, irq;
  logic [7:0] rdata, b, d;
  scbr_bus_t bus;
  scbr_pin_t mosi_p, miso_p, sel_p;
  scbr_ss_mode_t ssm;
  int n_mismatch, total_checks, seed, i, ntx;
  scbr_ctrl DUT (.MCLK_I(mclk), .RESETN_I(rst_n), .BUS_I(bus), .RDATA_O(rdata), .MASTER_SELECT_I(master),
    .SPI_ENABLE_I(en), .SELECT_OUTPUT_ENABLE_I(select_output_enable), .XFER_DONE_I(done), .TX_LOADED_I(loaded),
    .WAIT_MODE_I(waitm), .SELECT_PIN_I(sel_in), .AUTO_SELECT_I(auto), .SHIFT_OUT_I(shout),
    .MOSI_IN_I(mosi_in), .MISO_IN_I(miso_in), .MOSI_PIN_O(mosi_p), .MISO_PIN_O(miso_p),
    .SELECT_PIN_O(sel_p), .SHIFT_IN_O(shin), .SS_MODE_O(ssm), .SPI_CLK_RUN_O(run),
    .BIT_TICK_O(tick), .TX_WRITE_O(txw), .RX_READ_O(rxr), .IRQ_O(irq));
  scbr_peer u_peer (.mclk_i(mclk), .fault_i(fault), .mosi_pin_i(mosi_p), .miso_pin_i(miso_p),
    .sel_pin_i(sel_p), .mosi_o(mosi_in), .miso_o(miso_in), .sel_o(sel_in));
  ////////////////////////////////////////////////////////////
  task chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task wrt(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk) bus <= {a, v, 2'b10};
    @(posedge mclk) bus <= '0;
  endtask : wrt
  // Read data stands only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge mclk) bus <= {a, 8'h00, 2'b01};
    @(posedge mclk) bus <= '0;
    #1 b = rdata;
  endtask : rd
  function logic [15:0] f_per(input logic [7:0] v);
    return ({13'd0, v[6:4]} + 16'd1) * (16'd2 << v[2:0]);
  endfunction : f_per
  function scbr_ss_mode_t f_ss(input logic m, input logic fe, input logic so);
    return !m ? SCBR_SS_SLAVE_IN : !fe ? SCBR_SS_GPIO : so ? SCBR_SS_AUTO_OUT : SCBR_SS_FAULT_IN;
  endfunction : f_ss
  // Bounded wait for a tick, then count one whole bit period
  task per(input logic [7:0] v);
    int n;
    wrt(1, v);
    rd(1); chk(b, v & 8'h77);
    n = 0;
    do begin @(posedge mclk); #1 n++; end while (!tick && n < 3000);
    n = 0;
    do begin @(posedge mclk); #1 n++; end while (!tick && n < 3000);
    chk(n[15:0], f_per(v));
  endtask : per
  task stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  // Random shift-engine levels keep the data path checks busy
  always @(posedge mclk) {auto, shout} <= $random(seed);
  always @(posedge mclk) if (txw) ntx++;
  initial begin
    #320000 n_mismatch++;
    stop_test;
  end
  initial begin
    seed = 39777; rst_n = 0; bus = '0; master = 0; en = 0; select_output_enable = 0; done = 0;
    loaded = 0; waitm = 0; fault = 0; auto = 1; shout = 0; ntx = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1;
    rd(0); chk(b, 8'h00);
    rd(1); chk(b, 8'h00);
    rd(2); chk(b, 8'h20);
    wrt(2, 8'hFF); rd(2); chk(b, 8'h20);
    rd(7); chk(b, 8'h00);
    // Every pin-role combination with random junk in the other bits
    for (i = 0; i < 16; i++) begin
      d = $random(seed); d[4] = i[2]; d[0] = i[3];
      master <= i[0]; select_output_enable <= i[1]; en <= 1;
      wrt(0, d);
      rd(0); chk(b, d & 8'h1B);
      chk(ssm, f_ss(master, d[4], select_output_enable));
    end
    master <= 1; waitm <= 1; wrt(0, 8'h02);
    @(posedge mclk) #1 chk(run, 1'b0);
    wrt(0, 8'h00);
    @(posedge mclk) #1 chk(run, 1'b1);
    waitm <= 0;
    for (i = 0; i < 64; i++) begin
      d = $random(seed); d[6:4] = i[5:3]; d[2:0] = i[2:0];
      per(d);
    end
    // Data write clears the empty flag only after an armed status read
    rd(2); wrt(3, 8'hA5); #1 chk(ntx, 1);
    rd(2); chk(b[5], 1'b0);
    wrt(3, 8'h5A); #1 chk(ntx, 1);
    @(posedge mclk) loaded <= 1;
    @(posedge mclk) loaded <= 0;
    rd(2); chk(b[5], 1'b1);
    wrt(6, 8'h01);
    @(posedge mclk) done <= 1;
    @(posedge mclk) done <= 0;
    @(posedge mclk) #1 chk(irq, 1'b1);
    rd(2); chk(b[7], 1'b1);
    rd(3); rd(2); chk(b[7], 1'b0);
    rd(5); chk(b[0], 1'b1);
    chk(irq, 1'b0);
    wrt(6, 8'h00);
    @(posedge mclk) done <= 1;
    @(posedge mclk) done <= 0;
    @(posedge mclk) #1 chk(irq, 1'b0);
    // Second master pulls select low while fault input is chosen
    select_output_enable <= 0; wrt(0, 8'h10); fault <= 1;
    repeat (10) @(posedge mclk);
    fault <= 0;
    rd(2); chk(b[4], 1'b1);
    wrt(4, 8'h00); rd(2); chk(b[4], 1'b0);
    stop_test;
  end
endmodule : spi_ctrl2_baud_status_test
